// File: bench/prog_mem_model.sv
/*
  Program memory seen from the execution block: answers a read one cycle
  after the request and inverts its data lines on every cycle without a read.
  Assumes the core clock and reset of the block under test.
*/
`timescale 1ns/1ps
module prog_mem_model #(
  parameter int ADDR_W = 16 // program address width
) (
  input wire logic clk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic prog_rd, // read request pulse
  input wire logic [ADDR_W-1:0] prog_addr, // read address
  output logic [15:0] prog_data // program word
);
  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // outside the answer cycle the lines toggle, so a late capture shows up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_data <= 16'h0000;
    end else if (prog_rd) begin
      prog_data <= {prog_addr[7:0] ^ 8'ha5, prog_addr[15:8] ^ 8'h3c};
    end else begin
      prog_data <= ~prog_data;
    end
  end
endmodule : prog_mem_model

// File: bench/skip_table_xor_instr_exec_tb.sv
/*
  Self-checking bench: a driver notes each expected result in a queue, a
  monitor compares it when done pulses. Assumes the default address width.
*/
`timescale 1ns/1ps
module skip_table_xor_instr_exec_tb;
  import exec_pkg::*;
  typedef struct {
    logic aw; logic [7:0] acc; logic mw; logic [7:0] mem; logic zw; logic z; logic sk;
    logic [16:0] addr; logic [7:0] lat; logic [7:0] tpl; logic [7:0] tph; int due; int bsy;
  } note_t;
  logic clk, resetn, instr_valid, ptr_low_we, ptr_high_we;
  op_t opcode;
  logic [2:0] bit_sel;
  logic [7:0] acc_in, mem_rdata, pc_page, ptr_wdata, acc_out, mem_wdata, tpl_out, tph_out, latch_out;
  logic [15:0] prog_data, prog_addr;
  logic busy, done, skip, dummy_cycle, acc_we, mem_we, zero_flag, zero_we, prog_rd;
  logic [7:0] tpl, tph, lat, g_acc, g_mem;
  logic g_aw, g_mw, g_zw, g_z, g_sk;
  logic [16:0] g_addr;
  int num_errors, total_checks, cyc, g_bsy;
  integer seed;
  note_t q[$];

  skip_table_xor_instr_exec uut (.clk(clk), .resetn(resetn), .instr_valid(instr_valid),
    .opcode(opcode), .bit_sel(bit_sel), .acc_in(acc_in), .mem_rdata(mem_rdata),
    .pc_page(pc_page), .ptr_low_we(ptr_low_we), .ptr_high_we(ptr_high_we),
    .ptr_wdata(ptr_wdata), .prog_data(prog_data), .busy(busy), .done(done), .skip(skip),
    .dummy_cycle(dummy_cycle), .acc_out(acc_out), .acc_we(acc_we), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .zero_flag(zero_flag), .zero_we(zero_we), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .table_pointer_low(tpl_out), .table_pointer_high(tph_out),
    .table_high_latch(latch_out));
  prog_mem_model pmem (.clk(clk), .resetn(resetn), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .prog_data(prog_data));

  // ---------------------------------------------------------------
  // clock, cycle count, helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [15:0] word_at(logic [15:0] a);
    return {a[7:0] ^ 8'ha5, a[15:8] ^ 8'h3c};
  endfunction : word_at

  task automatic chk(string name, logic [47:0] e, logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  // two cycles, so low and high loads never share an edge
  task automatic load_ptrs(logic [7:0] lo, logic [7:0] hi);
    instr_valid <= 1'b0;
    ptr_low_we <= 1'b1;
    ptr_wdata <= lo;
    @(posedge clk);
    ptr_low_we <= 1'b0;
    ptr_high_we <= 1'b1;
    ptr_wdata <= hi;
    @(posedge clk);
    ptr_high_we <= 1'b0;
    tpl = lo;
    tph = hi;
  endtask : load_ptrs

  task automatic issue(op_t o, logic [7:0] a, logic [7:0] m, logic [2:0] b, logic [7:0] pg);
    note_t n;
    int lt;
    logic [7:0] r, pgx;
    logic [15:0] w;
    n = '{default: '0};
    lt = 1;
    r = a ^ m;
    case (o)
      swap_nibbles_to_acc: begin n.aw = 1; n.acc = {m[3:0], m[7:4]}; end
      skip_if_zero: n.sk = (m == 8'h00);
      copy_and_skip_if_zero: begin n.aw = 1; n.acc = m; n.sk = (m == 8'h00); end
      skip_if_bit_zero: n.sk = ~m[b];
      xor_to_acc: begin n.aw = 1; n.acc = r; n.zw = 1; n.z = (r == 8'h00); end
      xor_to_memory: begin n.mw = 1; n.mem = r; n.zw = 1; n.z = (r == 8'h00); end
      default: begin
        if (o == incr_table_read || o == incr_table_read_last_page) tpl = tpl + 8'h01;
        pgx = (o == table_read_current_page) ? pg : (o == incr_table_read) ? tph : 8'hff;
        w = word_at({pgx, tpl});
        n.addr = {1'b1, pgx, tpl};
        n.mw = 1;
        n.mem = w[7:0];
        lat = w[15:8];
        lt = 3;
      end
    endcase
    if (n.sk) lt = 2;
    n.lat = lat;
    n.tpl = tpl;
    n.tph = tph;
    n.due = cyc + 1 + lt;
    n.bsy = lt - 1;
    q.push_back(n);
    instr_valid <= 1'b1;
    opcode <= o;
    acc_in <= a;
    mem_rdata <= m;
    bit_sel <= b;
    pc_page <= pg;
    @(posedge clk);
    if (lt > 1) begin
      // offered while busy: must be ignored
      opcode <= xor_to_memory;
      mem_rdata <= ~m;
      repeat (lt - 1) @(posedge clk);
    end
  endtask : issue

  // ---------------------------------------------------------------
  // monitor: gathers write pulses, compares at done
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    note_t n;
    if (resetn) begin
      if (acc_we) begin g_aw = 1; g_acc = acc_out; end
      if (mem_we) begin g_mw = 1; g_mem = mem_wdata; end
      if (zero_we) begin g_zw = 1; g_z = zero_flag; end
      if (skip) g_sk = 1;
      if (prog_rd) g_addr = {1'b1, prog_addr};
      if (busy) g_bsy++;
      if (done) begin
        if (q.size() == 0) begin
          chk("spare_done", 48'h0, 48'h1);
        end else begin
          n = q.pop_front();
          chk("acc_write", {n.aw, n.acc}, {g_aw, g_acc});
          chk("mem_write", {n.mw, n.mem}, {g_mw, g_mem});
          chk("zero_write", {n.zw, n.z}, {g_zw, g_z});
          chk("skip_dummy", {n.sk, n.sk}, {g_sk, dummy_cycle});
          chk("done_cycle", n.due, cyc);
          chk("prog_addr", n.addr, g_addr);
          chk("latch", n.lat, latch_out);
          chk("pointers", {n.tph, n.tpl}, {tph_out, tpl_out});
          chk("busy_cycles", n.bsy, g_bsy);
        end
        {g_aw, g_mw, g_zw, g_z, g_sk, g_acc, g_mem, g_addr} = '0;
        g_bsy = 0;
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    op_t o;
    logic [7:0] a, m;
    seed = 32'hc089;
    {instr_valid, ptr_low_we, ptr_high_we, bit_sel, acc_in, mem_rdata, pc_page} = '0;
    {ptr_wdata, tpl, tph, lat, g_acc, g_mem, g_addr, g_aw, g_mw, g_zw, g_z, g_sk} = '0;
    opcode = swap_nibbles_to_acc;
    num_errors = 0;
    total_checks = 0;
    cyc = 0;
    resetn = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("reset_state", 48'h0, {prog_addr, tpl_out, tph_out, latch_out});
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < 6; k++) begin
        o = op_t'(i);
        a = 8'($random(seed));
        m = 8'($random(seed));
        if (k[0]) m = (o == xor_to_acc || o == xor_to_memory) ? a : 8'h00;
        if (k == 2) load_ptrs(8'hff, 8'($random(seed)));
        if (k == 4) load_ptrs(8'($random(seed)), 8'($random(seed)));
        issue(o, a, m, 3'($random(seed)), 8'($random(seed)));
      end
    end
    instr_valid <= 1'b0;
    repeat (6) @(posedge clk);
    chk("queue_left", 48'h0, q.size());
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
endmodule : skip_table_xor_instr_exec_tb

// File: rtl/exec_alu.sv
/*
  Combinational operand unit: nibble swap, zero tests and XOR.
  Assumes operands are stable in the cycle an instruction is taken.
*/
`timescale 1ns/1ps
module exec_alu
  import exec_pkg::*;
(
  exec_if.alu bus // operands in, result and skip decision out
);

  // ---------------------------------------------------------------------------
  // result and skip decision
  // ---------------------------------------------------------------------------
  always_comb begin
    bus.result = bus.mem;
    bus.skip = 1'b0;
    case (bus.op)
      swap_nibbles_to_acc: bus.result = {bus.mem[NIB_W-1:0], bus.mem[DATA_W-1:NIB_W]};
      skip_if_zero: bus.skip = (bus.mem == BYTE_ZERO);
      copy_and_skip_if_zero: bus.skip = (bus.mem == BYTE_ZERO);
      skip_if_bit_zero: bus.skip = ~bus.mem[bus.bit_sel];
      xor_to_acc: bus.result = bus.acc ^ bus.mem;
      xor_to_memory: bus.result = bus.acc ^ bus.mem;
      default: bus.result = bus.mem;
    endcase
  end

  // zero test of the result of every op; only the XOR ops write it to the flag
  assign bus.zero = (bus.result == BYTE_ZERO);

endmodule : exec_alu

// File: rtl/exec_if.sv
/*
  Carrier between the sequencing top and its combinational operand unit.
  Assumes both ends sit in the same clock domain; no storage inside.
*/
`timescale 1ns/1ps
interface exec_if;
  import exec_pkg::*;
  op_t op;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] mem;
  logic [BIT_SEL_W-1:0] bit_sel;
  logic [DATA_W-1:0] result;
  logic skip;
  logic zero;
  modport core (output op, acc, mem, bit_sel, input result, skip, zero);
  modport alu (input op, acc, mem, bit_sel, output result, skip, zero);
endinterface : exec_if

// File: rtl/exec_pkg.sv
/*
  Shared constants, opcode and state enumerations and decode helpers for the
  skip / table-read / XOR execution block.
  Assumes a single core clock and an 8-bit data path with 16-bit program words.
*/
package exec_pkg;

  // ---------------------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 8;          // data memory byte
  localparam int PROG_DATA_W = 16;    // program word
  localparam int PROG_ADDR_W = 16;    // default program address width
  localparam int PTR_LOW_W = 8;       // low table pointer, also the in-page offset
  localparam int NIB_W = 4;           // nibble
  localparam int BIT_SEL_W = 3;       // bit index inside a byte
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] PTR_STEP = 8'h01;
  localparam logic [DATA_W-1:0] PTR_RESET = 8'h00;
  localparam logic [PROG_DATA_W-DATA_W-1:0] LATCH_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // opcodes and sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    swap_nibbles_to_acc,
    skip_if_zero,
    copy_and_skip_if_zero,
    skip_if_bit_zero,
    table_read_current_page,
    table_read_last_page,
    incr_table_read,
    incr_table_read_last_page,
    xor_to_acc,
    xor_to_memory
  } op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_prog_wait,
    st_prog_cap,
    st_dummy
  } state_t;

  // ---------------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_table(input op_t op);
    is_table = (op == table_read_current_page) || (op == table_read_last_page) ||
               (op == incr_table_read) || (op == incr_table_read_last_page);
  endfunction : is_table

  function automatic logic is_last_page(input op_t op);
    is_last_page = (op == table_read_last_page) || (op == incr_table_read_last_page);
  endfunction : is_last_page

  function automatic logic is_pre_incr(input op_t op);
    is_pre_incr = (op == incr_table_read) || (op == incr_table_read_last_page);
  endfunction : is_pre_incr

endpackage : exec_pkg

// File: rtl/skip_table_xor_instr_exec.sv
/*
  Execution unit for nibble swap, zero skips, program-memory table reads and
  XOR, driven by the core sequencer one instruction at a time.
  Assumes the sequencer presents the addressed byte and the accumulator with
  instr_valid, and program memory answers one cycle after prog_rd.
*/
`timescale 1ns/1ps

module skip_table_xor_instr_exec
  import exec_pkg::*;
#(
  parameter int ADDR_W = PROG_ADDR_W // program address width
) (
  input wire logic clk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic instr_valid, // instruction offered
  input op_t opcode, // instruction to execute
  input wire logic [BIT_SEL_W-1:0] bit_sel, // bit index for bit test
  input wire logic [DATA_W-1:0] acc_in, // current accumulator
  input wire logic [DATA_W-1:0] mem_rdata, // addressed data byte
  input wire logic [ADDR_W-PTR_LOW_W-1:0] pc_page, // page of current program counter
  input wire logic ptr_low_we, // load low table pointer
  input wire logic ptr_high_we, // load high table pointer
  input wire logic [DATA_W-1:0] ptr_wdata, // pointer load value
  input wire logic [PROG_DATA_W-1:0] prog_data, // program word, cycle after prog_rd
  output logic busy, // instruction in progress
  output logic done, // instruction finished pulse
  output logic skip, // next instruction skipped pulse
  output logic dummy_cycle, // inserted dummy cycle pulse
  output logic [DATA_W-1:0] acc_out, // new accumulator value
  output logic acc_we, // accumulator write pulse
  output logic [DATA_W-1:0] mem_wdata, // data byte write value
  output logic mem_we, // data byte write pulse
  output logic zero_flag, // new zero flag
  output logic zero_we, // zero flag write pulse
  output logic prog_rd, // program memory read pulse
  output logic [ADDR_W-1:0] prog_addr, // program memory address
  output logic [DATA_W-1:0] table_pointer_low, // low table pointer
  output logic [DATA_W-1:0] table_pointer_high, // high table pointer
  output logic [PROG_DATA_W-DATA_W-1:0] table_high_latch // high byte of last table word
);

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  // page bits come from an 8-bit high pointer, so at most 8 of them
  if (ADDR_W <= PTR_LOW_W || ADDR_W > PTR_LOW_W + DATA_W) begin : g_bad_addr_w
    $error("ADDR_W must lie between 9 and 16");
  end

  localparam int PAGE_W = ADDR_W - PTR_LOW_W;

  state_t state_reg;
  state_t state_next;
  logic take;
  logic [DATA_W-1:0] ptr_low_next;
  logic [PAGE_W-1:0] page_sel;
  exec_if alu_bus ();

  // ---------------------------------------------------------------------------
  // operand unit
  // ---------------------------------------------------------------------------
  assign alu_bus.op = opcode;
  assign alu_bus.acc = acc_in;
  assign alu_bus.mem = mem_rdata;
  assign alu_bus.bit_sel = bit_sel;

  exec_alu u_alu (
    .bus (alu_bus)
  );

  assign take = instr_valid && !busy;

  // ---------------------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------------------
  // next state; a table read waits for the memory, a skip adds one cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (take && is_table(opcode)) begin
          state_next = st_prog_wait;
        end else if (take && alu_bus.skip) begin
          state_next = st_dummy;
        end
      end
      st_prog_wait: state_next = st_prog_cap;
      st_prog_cap: state_next = st_idle;
      st_dummy: state_next = st_idle;
      default: state_next = st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= st_idle;
      busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy <= (state_next != st_idle);
    end
  end

  // completion, skip and dummy pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
      skip <= 1'b0;
      dummy_cycle <= 1'b0;
    end else begin
      skip <= take && !is_table(opcode) && alu_bus.skip;
      dummy_cycle <= (state_reg == st_dummy);
      done <= (take && !is_table(opcode) && !alu_bus.skip) ||
              (state_reg == st_dummy) || (state_reg == st_prog_cap);
    end
  end

  // ---------------------------------------------------------------------------
  // accumulator, data byte and zero flag
  // ---------------------------------------------------------------------------
  // table reads and skips other than copy_and_skip_if_zero leave the accumulator and every flag alone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_out <= BYTE_ZERO;
      acc_we <= 1'b0;
    end else begin
      acc_we <= take && ((opcode == swap_nibbles_to_acc) ||
                         (opcode == copy_and_skip_if_zero) ||
                         (opcode == xor_to_acc));
      if (take) begin
        acc_out <= alu_bus.result;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zero_flag <= 1'b0;
      zero_we <= 1'b0;
    end else begin
      zero_we <= take && ((opcode == xor_to_acc) || (opcode == xor_to_memory));
      if (take) begin
        zero_flag <= alu_bus.zero;
      end
    end
  end

  // data byte write: XOR result at once, table low byte on capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_wdata <= BYTE_ZERO;
      mem_we <= 1'b0;
    end else begin
      mem_we <= (take && (opcode == xor_to_memory)) || (state_reg == st_prog_cap);
      if (state_reg == st_prog_cap) begin
        mem_wdata <= prog_data[DATA_W-1:0];
      end else if (take) begin
        mem_wdata <= alu_bus.result;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // table pointers and program memory read
  // ---------------------------------------------------------------------------
  // the increment wraps inside the low byte and never carries into the page
  assign ptr_low_next = (take && is_pre_incr(opcode)) ?
                        DATA_W'(table_pointer_low + PTR_STEP) : table_pointer_low;

  // page source: all ones for last page, high pointer after pre-increment
  always_comb begin
    if (is_last_page(opcode)) begin
      page_sel = '1;
    end else if (opcode == incr_table_read) begin
      page_sel = table_pointer_high[PAGE_W-1:0];
    end else begin
      page_sel = pc_page;
    end
  end

  // a low pointer load that meets a pre-increment is dropped so the read address stays coherent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      table_pointer_low <= PTR_RESET;
    end else if (take && is_pre_incr(opcode)) begin
      table_pointer_low <= ptr_low_next;
    end else if (ptr_low_we) begin
      table_pointer_low <= ptr_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      table_pointer_high <= PTR_RESET;
    end else if (ptr_high_we) begin
      table_pointer_high <= ptr_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_rd <= 1'b0;
      prog_addr <= '0;
    end else begin
      prog_rd <= take && is_table(opcode);
      if (take && is_table(opcode)) begin
        prog_addr <= {page_sel, ptr_low_next};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      table_high_latch <= LATCH_RESET;
    end else if (state_reg == st_prog_cap) begin
      table_high_latch <= prog_data[PROG_DATA_W-1:DATA_W];
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_swap_result: assert property (take && opcode == swap_nibbles_to_acc |=>
    acc_we && !zero_we && !mem_we &&
    acc_out == {$past(mem_rdata[NIB_W-1:0]), $past(mem_rdata[DATA_W-1:NIB_W])})
    else $error("swap result wrong");

  a_zero_skip: assert property (take && opcode == skip_if_zero |=>
    skip == ($past(mem_rdata) == BYTE_ZERO) && !acc_we && !zero_we)
    else $error("zero skip wrong");

  // busy is checked in the dummy cycle itself, since a new take may follow it at once
  a_skip_dummy: assert property (skip |-> busy && !done ##1 (dummy_cycle && done && !busy))
    else $error("skip without one dummy cycle");

  a_copy_skip: assert property (take && opcode == copy_and_skip_if_zero |=>
    acc_we && acc_out == $past(mem_rdata) && skip == ($past(mem_rdata) == BYTE_ZERO))
    else $error("copy and skip wrong");

  a_bit_skip: assert property (take && opcode == skip_if_bit_zero |=>
    skip == !$past(mem_rdata[bit_sel]) && !acc_we)
    else $error("bit skip wrong");

  a_table_capture: assert property (prog_rd |=> ##1 (mem_we && done &&
    mem_wdata == $past(prog_data[DATA_W-1:0]) &&
    table_high_latch == $past(prog_data[PROG_DATA_W-1:DATA_W])))
    else $error("table word not captured");

  a_current_page: assert property (take && opcode == table_read_current_page |=>
    prog_rd && prog_addr == {$past(pc_page), $past(table_pointer_low)})
    else $error("current page address wrong");

  a_last_page: assert property (take && opcode == table_read_last_page |=>
    prog_rd && prog_addr == {{PAGE_W{1'b1}}, $past(table_pointer_low)})
    else $error("last page address wrong");

  a_incr_read: assert property (take && opcode == incr_table_read |=>
    table_pointer_low == DATA_W'($past(table_pointer_low) + PTR_STEP) &&
    prog_addr == {$past(table_pointer_high[PAGE_W-1:0]), table_pointer_low})
    else $error("pre-increment read wrong");

  a_incr_last: assert property (take && opcode == incr_table_read_last_page |=>
    $stable(table_pointer_high) && prog_addr == {{PAGE_W{1'b1}}, table_pointer_low} &&
    table_pointer_low == DATA_W'($past(table_pointer_low) + PTR_STEP))
    else $error("pre-increment last page read wrong");

  a_xor_acc: assert property (take && opcode == xor_to_acc |=>
    acc_we && zero_we && !mem_we && acc_out == ($past(acc_in) ^ $past(mem_rdata)) &&
    zero_flag == (($past(acc_in) ^ $past(mem_rdata)) == BYTE_ZERO))
    else $error("xor to accumulator wrong");

  a_xor_mem: assert property (take && opcode == xor_to_memory |=>
    mem_we && zero_we && !acc_we && mem_wdata == ($past(acc_in) ^ $past(mem_rdata)) &&
    zero_flag == (($past(acc_in) ^ $past(mem_rdata)) == BYTE_ZERO))
    else $error("xor to memory wrong");

endmodule : skip_table_xor_instr_exec
